// ---- sdc_pkg.sv ----
// Constants, encodings and lookup helpers for the decay chopper
package sdc_pkg;
	localparam int CLK_MHZ = 50;
	// Printed times in nanoseconds, converted to cycles rounding up
	localparam int BLANK_0900_NS = 900;
	localparam int BLANK_1200_NS = 1200;
	localparam int BLANK_1500_NS = 1500;
	localparam int BLANK_1800_NS = 1800;
	localparam int OFF_10_NS     = 10000;
	localparam int OFF_20_NS     = 20000;
	localparam int OFF_30_NS     = 30000;
	localparam logic [11:0] BLANK_0900 = 12'((BLANK_0900_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] BLANK_1200 = 12'((BLANK_1200_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] BLANK_1500 = 12'((BLANK_1500_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] BLANK_1800 = 12'((BLANK_1800_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] OFF_10     = 12'((OFF_10_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] OFF_20     = 12'((OFF_20_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] OFF_30     = 12'((OFF_30_NS * CLK_MHZ + 999) / 1000);
	// Register map (byte addresses) and reset values
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_TIMING = 8'h08;
	localparam logic        CTRL_RST    = 1'h1;
	// Tri-level pin codes
	localparam logic [1:0]  TRI_LO = 2'h0;
	localparam logic [1:0]  TRI_HI = 2'h1;
	localparam logic [1:0]  TRI_Z  = 2'h2;
	// Step mode code that means full step
	localparam logic [3:0]  FULL_STEP_CODE = 4'h0;
	// Fixed fast fractions in tenths
	localparam logic [3:0]  FRAC_30 = 4'h3;
	localparam logic [3:0]  FRAC_60 = 4'h6;
	typedef enum logic [2:0] {
		D_SLOW = 3'h0, D_M30 = 3'h1, D_M60 = 3'h2, D_M1B = 3'h3,
		D_M2B = 3'h4, D_FAST = 3'h5, D_MAD = 3'h6
	} sdc_decay_e;
	typedef enum logic [1:0] {
		S_IDLE = 2'h0, S_DRIVE = 2'h1, S_FAST = 2'h3, S_SLOW = 2'h2
	} sdc_state_e;
	// Decay pair for a decay-select code: {increasing, decreasing}
	function automatic logic [5:0] sdc_pair(input logic [1:0] hi, input logic [1:0] lo);
		logic [5:0] p;
		p = {D_SLOW, D_SLOW};
		case ({hi, lo})
			{TRI_LO, TRI_HI}: p = {D_SLOW, D_M2B};
			{TRI_HI, TRI_LO}: p = {D_SLOW, D_M30};
			{TRI_HI, TRI_HI}: p = {D_M30, D_M30};
			{TRI_LO, TRI_Z}:  p = {D_SLOW, D_M60};
			{TRI_HI, TRI_Z}:  p = {D_SLOW, D_FAST};
			{TRI_Z, TRI_LO}:  p = {D_M1B, D_M30};
			{TRI_Z, TRI_HI}:  p = {D_M60, D_M60};
			{TRI_Z, TRI_Z}:   p = {D_FAST, D_FAST};
			default:          p = {D_SLOW, D_SLOW};
		endcase
		return p;
	endfunction : sdc_pair
endpackage : sdc_pkg

// ---- sdc_chopper.sv ----
// Decay chopper with adaptive blanking, adaptive tuning and undervoltage handling
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Mixed decay runs fast decay first, then slow decay for remaining off time.
// - Mixed/mixed setting uses mixed decay on rising and falling microsteps.
// - Fast decay reverses the bridge and turns it off near zero current.
// - Slow/fast setting: fast only on falling steps, slow on rising steps.
// - Fast/fast setting uses fast decay on both step directions.
// - Tuning selection is captured only at power-up or sleep exit.
// - Tuning picks slow, mixed or fast itself and varies the fast fraction.
// - Overshoot in a cycle raises the fast fraction for the next cycle.
// - Long drive time lowers the fast fraction for the next cycle.
// - Tuning uses fast decay on falling-current microsteps.
// - Comparator ignored for the blanking interval, also the minimum drive time.
// - Full torque: 1.8/1.5/1.2/0.9 us by sine code band.
// - 75% torque: 1.5 us codes 5-16, 1.2 us 3-4, 0.9 us 1-2.
// - 50% torque 1.5/1.2/0.9 us; 25% torque 1.2 us high codes, else 0.9.
// - Supply undervoltage stops bridge and pump, fault low; release after resume.
// - Supply undervoltage keeps logic and indexer position alive.
// - Logic undervoltage resets logic and indexer and stops the aux regulator.
// - Fault output stays low throughout logic undervoltage.
// - Off-time, step-mode and decay pins are tri-level; the rest two-level.
// - Undriven two-level inputs read low through the weak pulldown.
// - Off-time pin: low 20 us, high 30 us, floating 10 us.
// - Tuning pin high overrides the decay-select pins.
// - Full-step mode always uses the increasing-step decay setting.
// - Decay-select pins map to the nine slow, mixed and fast pairings.
module sdc_chopper #(
	parameter int AF_MAX    = 8,
	parameter int LONG_MULT = 2
) (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        OFF_TIME_SELECT_LVL,
	input  wire logic        OFF_TIME_SELECT_FLT,
	input  wire logic        DECAY_SELECT_LO_LVL,
	input  wire logic        DECAY_SELECT_LO_FLT,
	input  wire logic        DECAY_SELECT_HI_LVL,
	input  wire logic        DECAY_SELECT_HI_FLT,
	input  wire logic        STEP_MODE_SELECT_LO_LVL,
	input  wire logic        STEP_MODE_SELECT_LO_FLT,
	input  wire logic        STEP_MODE_SELECT_HI_LVL,
	input  wire logic        STEP_MODE_SELECT_HI_FLT,
	input  wire logic        TORQUE_SCALE_LO,
	input  wire logic        TORQUE_SCALE_HI,
	input  wire logic        TUNING_ENABLE_PIN,
	input  wire logic        SLEEP_IN_N,
	input  wire logic        ENABLE_IN,
	input  wire logic [4:0]  PIN_UNDRIVEN,
	input  wire logic [4:0]  SINE_CODE,
	input  wire logic        CURRENT_INCREASING,
	input  wire logic        WINDING_SENSE_INPUT,
	input  wire logic        CURRENT_NEAR_ZERO,
	input  wire logic        SUPPLY_UNDERVOLTAGE,
	input  wire logic        LOGIC_UNDERVOLTAGE,
	input  wire logic        FAULT_OUT_N_I,
	output logic             FAULT_OUT_N_O,
	output logic             FAULT_OUT_N_OE_N,
	output logic             BRIDGE_DRIVE,
	output logic             BRIDGE_FAST,
	output logic             BRIDGE_SLOW,
	output logic             SENSE_BLANKED,
	output logic             CHARGE_PUMP_EN,
	output logic             AUX_REGULATOR_EN,
	output logic             INDEXER_RUN
);
	import sdc_pkg::*;

	logic        rst;
	logic        rst_d;
	logic        sleep_d;
	logic        capture;
	logic        adaptive_on;
	logic        chop_en;
	logic [1:0]  trq;
	logic        tuning_enable_pin;
	logic        sleep_n;
	logic        enable;
	logic [1:0]  off_time_select_tri;
	logic [1:0]  dlo_tri;
	logic [1:0]  dhi_tri;
	logic [3:0]  mode_code;
	logic [11:0] blank_cyc;
	logic [11:0] off_time_select_cyc;
	logic [5:0]  pair;
	logic        inc_step;
	sdc_decay_e  eff_mode;
	logic [11:0] fast_cyc;
	logic [3:0]  afrac;
	sdc_state_e  state;
	sdc_state_e  next_state;
	logic [11:0] blank_left;
	logic [11:0] off_left;
	logic [11:0] fast_left;
	logic [12:0] drv_cnt;
	logic        fast_stop;
	logic        full_fast;
	logic        run;
	logic        tripped;
	logic        overshoot;
	logic        long_drive;
	logic        bridge_ok_d;
	logic        fault_n;

	// Logic undervoltage acts as a reset of all internal state except the fault flops, which only SYS_RST resets
	assign rst = SYS_RST | LOGIC_UNDERVOLTAGE;

	// Two-level pins: an undriven pin reads low through its pulldown
	assign trq     = {TORQUE_SCALE_HI & ~PIN_UNDRIVEN[1], TORQUE_SCALE_LO & ~PIN_UNDRIVEN[0]};
	assign tuning_enable_pin     = TUNING_ENABLE_PIN & ~PIN_UNDRIVEN[2];
	assign sleep_n = SLEEP_IN_N & ~PIN_UNDRIVEN[3];
	assign enable  = ENABLE_IN & ~PIN_UNDRIVEN[4];

	// Tri-level pins: floating beats the sensed level
	assign off_time_select_tri  = OFF_TIME_SELECT_FLT ? TRI_Z : {1'b0, OFF_TIME_SELECT_LVL};
	assign dlo_tri   = DECAY_SELECT_LO_FLT ? TRI_Z : {1'b0, DECAY_SELECT_LO_LVL};
	assign dhi_tri   = DECAY_SELECT_HI_FLT ? TRI_Z : {1'b0, DECAY_SELECT_HI_LVL};
	assign mode_code = {STEP_MODE_SELECT_HI_FLT ? TRI_Z : {1'b0, STEP_MODE_SELECT_HI_LVL},
		STEP_MODE_SELECT_LO_FLT ? TRI_Z : {1'b0, STEP_MODE_SELECT_LO_LVL}};

	// Off interval from the off-time pin
	always_comb
	begin
		case (off_time_select_tri)
			TRI_LO:  off_time_select_cyc = OFF_20;
			TRI_HI:  off_time_select_cyc = OFF_30;
			default: off_time_select_cyc = OFF_10;
		endcase
	end

	// Blanking interval by torque scale and sine code band
	always_comb
	begin
		blank_cyc = BLANK_0900;
		if (SINE_CODE >= 5'h09)
		begin
			case (trq)
				2'h0:    blank_cyc = BLANK_1800;
				2'h3:    blank_cyc = BLANK_1200;
				default: blank_cyc = BLANK_1500;
			endcase
		end
		else if (SINE_CODE >= 5'h05)
		begin
			case (trq)
				2'h0, 2'h1: blank_cyc = BLANK_1500;
				2'h2:       blank_cyc = BLANK_1200;
				default:    blank_cyc = BLANK_0900;
			endcase
		end
		else if (SINE_CODE >= 5'h03)
		begin
			blank_cyc = trq[1] ? BLANK_0900 : BLANK_1200;
		end
	end

	// Effective decay for this cycle; full step always counts as increasing
	assign pair     = sdc_pair(dhi_tri, dlo_tri);
	assign inc_step = CURRENT_INCREASING | (mode_code == FULL_STEP_CODE);
	always_comb
	begin
		if (adaptive_on)
		begin
			if (!inc_step)
				eff_mode = D_FAST;
			else if (afrac == 4'h0)
				eff_mode = D_SLOW;
			else if (afrac == 4'(AF_MAX))
				eff_mode = D_FAST;
			else
				eff_mode = D_MAD;
		end
		else
			eff_mode = sdc_decay_e'(inc_step ? pair[5:3] : pair[2:0]);
	end

	// Fast portion of the off interval
	always_comb
	begin
		case (eff_mode)
			D_M30:   fast_cyc = 12'((16'(off_time_select_cyc) * 16'(FRAC_30)) / 16'd10);
			D_M60:   fast_cyc = 12'((16'(off_time_select_cyc) * 16'(FRAC_60)) / 16'd10);
			D_M1B:   fast_cyc = blank_cyc;
			D_M2B:   fast_cyc = 12'({blank_cyc, 1'b0});
			D_FAST:  fast_cyc = off_time_select_cyc;
			D_MAD:   fast_cyc = 12'((16'(off_time_select_cyc) * 16'(afrac)) / 16'(AF_MAX));
			default: fast_cyc = 12'h000;
		endcase
	end

	// Tuning selection is sampled at reset release or sleep exit only
	assign capture = (rst_d & ~rst) | (sleep_n & ~sleep_d);
	always_ff @(posedge CLK)
	begin
		if (rst)
		begin
			rst_d       <= 1'b1;
			sleep_d     <= 1'b1;
			adaptive_on <= 1'b0;
		end
		else
		begin
			rst_d   <= 1'b0;
			sleep_d <= sleep_n;
			if (capture)
				adaptive_on <= tuning_enable_pin;
		end
	end

	// Chopper may run only when awake, enabled and supply is good
	assign run        = sleep_n & enable & ~SUPPLY_UNDERVOLTAGE & chop_en;
	assign tripped    = (state == S_DRIVE) && (blank_left == 12'h000) && WINDING_SENSE_INPUT;
	assign overshoot  = tripped && (drv_cnt == 13'(blank_cyc));
	assign long_drive = tripped && (drv_cnt > 13'(LONG_MULT) * 13'(blank_cyc));
	assign full_fast  = (off_left == fast_left);

	// Next chopper state
	always_comb
	begin
		next_state = state;
		case (state)
			S_IDLE:
				if (run)
					next_state = S_DRIVE;
			S_DRIVE:
				if (tripped)
					next_state = (fast_cyc != 12'h000) ? S_FAST : S_SLOW;
			S_FAST:
				if (off_left == 12'h000)
					next_state = S_DRIVE;
				else if (!full_fast && (fast_left == 12'h000 || CURRENT_NEAR_ZERO))
					next_state = S_SLOW;
			S_SLOW:
				if (off_left == 12'h000)
					next_state = S_DRIVE;
			default:
				next_state = S_IDLE;
		endcase
		if (!run)
			next_state = S_IDLE;
	end

	// State and interval counters
	always_ff @(posedge CLK)
	begin
		if (rst)
		begin
			state      <= S_IDLE;
			blank_left <= 12'h000;
			off_left   <= 12'h000;
			fast_left  <= 12'h000;
			drv_cnt    <= 13'h0000;
			fast_stop  <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (next_state == S_DRIVE && state != S_DRIVE)
			begin
				blank_left <= blank_cyc - 12'h001;
				drv_cnt    <= 13'h0001;
			end
			else if (state == S_DRIVE)
			begin
				if (blank_left != 12'h000)
					blank_left <= blank_left - 12'h001;
				if (drv_cnt != 13'h1fff)
					drv_cnt <= drv_cnt + 13'h0001;
			end
			if (tripped)
			begin
				off_left  <= off_time_select_cyc - 12'h001;
				fast_left <= (fast_cyc == 12'h000) ? 12'h000 : fast_cyc - 12'h001;
				fast_stop <= 1'b0;
			end
			else
			begin
				if (off_left != 12'h000)
					off_left <= off_left - 12'h001;
				if (fast_left != 12'h000)
					fast_left <= fast_left - 12'h001;
				if (state == S_FAST && CURRENT_NEAR_ZERO)
					fast_stop <= 1'b1;
			end
		end
	end

	// Adaptive fast fraction, one unit per PWM cycle, saturating
	always_ff @(posedge CLK)
	begin
		if (rst)
			afrac <= 4'h0;
		else if (adaptive_on && tripped)
		begin
			if (overshoot && afrac != 4'(AF_MAX))
				afrac <= afrac + 4'h1;
			else if (long_drive && afrac != 4'h0)
				afrac <= afrac - 4'h1;
		end
	end

	// Fault output released one cycle after the bridge is back
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			bridge_ok_d <= 1'b0;
			fault_n     <= 1'b0;
		end
		else
		begin
			bridge_ok_d <= ~SUPPLY_UNDERVOLTAGE & ~LOGIC_UNDERVOLTAGE;
			fault_n     <= bridge_ok_d & ~SUPPLY_UNDERVOLTAGE & ~LOGIC_UNDERVOLTAGE;
		end
	end

	// Bridge, supplies and indexer; fast drive drops near zero current
	assign BRIDGE_DRIVE     = (state == S_DRIVE);
	assign BRIDGE_FAST      = (state == S_FAST) && !fast_stop;
	assign BRIDGE_SLOW      = (state == S_SLOW);
	assign SENSE_BLANKED    = (state == S_DRIVE) && (blank_left != 12'h000);
	assign CHARGE_PUMP_EN   = sleep_d & ~rst_d & ~SUPPLY_UNDERVOLTAGE;
	assign AUX_REGULATOR_EN = sleep_d & ~rst_d;
	assign INDEXER_RUN      = sleep_d & ~rst_d;
	assign FAULT_OUT_N_O    = 1'b0;
	assign FAULT_OUT_N_OE_N = fault_n; // Open drain: enable low pulls the line down

	// APB slave, zero wait states; read data is latched in the setup cycle
	assign PREADY = 1'b1;
	always_ff @(posedge CLK)
	begin
		if (rst)
		begin
			chop_en <= CTRL_RST;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end
		else
		begin
			if (PSEL && !PENABLE)
			begin
				PSLVERR <= !(PADDR == ADDR_CTRL || PADDR == ADDR_STATUS || PADDR == ADDR_TIMING);
				case (PADDR)
					ADDR_CTRL:   PRDATA <= {31'h0, chop_en};
					ADDR_STATUS: PRDATA <= {16'h0, FAULT_OUT_N_I, fast_stop, adaptive_on, eff_mode,
						afrac, 4'h0, state};
					ADDR_TIMING: PRDATA <= {4'h0, off_time_select_cyc, 4'h0, blank_cyc};
					default:     PRDATA <= 32'h0000_0000;
				endcase
			end
			if (PSEL && PENABLE && PWRITE && PADDR == ADDR_CTRL)
				chop_en <= PWDATA[0];
		end
	end

	// Checks on the chopper
	default clocking cb @(posedge CLK); endclocking
	default disable iff (rst);

	sequence fast_phase;
		state == S_FAST && !full_fast && off_left != 12'h000 && fast_left == 12'h000;
	endsequence
	sequence enter_drive;
		state != S_DRIVE && next_state == S_DRIVE;
	endsequence

	chk_mixed_fast_slow: assert property (fast_phase ##0 run |=> state == S_SLOW)
		else $error("mixed decay did not move to slow");
	chk_blank_hold: assert property (disable iff (rst || !run)
		enter_drive |=> (state == S_DRIVE && SENSE_BLANKED) [*8])
		else $error("blanking interval cut short");
	chk_blank_full: assert property (trq == 2'h0 && SINE_CODE >= 5'h09 |-> blank_cyc == 12'd90)
		else $error("full torque blanking wrong");
	chk_blank_low: assert property (trq == 2'h3 && SINE_CODE <= 5'h08 |-> blank_cyc == 12'd45)
		else $error("quarter torque blanking wrong");
	chk_fast_zero: assert property (state == S_FAST && CURRENT_NEAR_ZERO && !tripped
		&& next_state == S_FAST |=> !BRIDGE_FAST)
		else $error("fast decay kept after zero current");
	chk_uv_bridge: assert property (SUPPLY_UNDERVOLTAGE |=> state == S_IDLE && !fault_n)
		else $error("bridge or fault wrong in undervoltage");
	chk_fault_release: assert property ($rose(fault_n) |-> $past(bridge_ok_d) && !$past(SUPPLY_UNDERVOLTAGE))
		else $error("fault released before resume");
	chk_tune_latched: assert property (!capture |=> $stable(adaptive_on))
		else $error("tuning selection changed outside capture");
	chk_frac_step: assert property (adaptive_on && tripped && overshoot && afrac < 4'(AF_MAX)
		|=> afrac == $past(afrac) + 4'h1)
		else $error("fraction did not rise after overshoot");
	chk_frac_bound: assert property (afrac <= 4'(AF_MAX))
		else $error("fraction out of range");
	chk_off_time_select_map: assert property (off_time_select_tri == TRI_Z |-> off_time_select_cyc == 12'd500)
		else $error("floating off time wrong");
	chk_fall_fast: assert property (adaptive_on && !inc_step |-> eff_mode == D_FAST)
		else $error("tuning not fast on falling step");
endmodule : sdc_chopper
`default_nettype wire

// ---- sdc_bridge_model.sv ----
// Behavioural H-bridge winding and sense comparator facing the chopper
`timescale 1ns/1ps
`default_nettype none
module sdc_bridge_model (
	input  wire logic        clk,
	input  wire logic        bridge_drive,
	input  wire logic        bridge_fast,
	input  wire logic [11:0] trip_dly,
	input  wire logic [11:0] zero_dly,
	output logic             sense_trip,
	output logic             near_zero
);
	logic [11:0] drv_cnt = 12'h000;
	logic [11:0] fst_cnt = 12'h000;
	// Winding current rises only while driven and decays only during fast decay
	always_ff @(posedge clk)
	begin
		drv_cnt <= bridge_drive ? drv_cnt + 12'h001 : 12'h000;
		fst_cnt <= bridge_fast ? fst_cnt + 12'h001 : (bridge_drive ? 12'h000 : fst_cnt);
	end
	// Trip delay sets a prompt or a slow comparator; it drops once drive stops
	assign sense_trip = bridge_drive && (drv_cnt >= trip_dly);
	// Current reaches zero after a programmed fast decay time
	assign near_zero = !bridge_drive && (fst_cnt >= zero_dly);
endmodule : sdc_bridge_model
`default_nettype wire

// ---- test_stepper_decay_chopper_control.sv ----
// Self-checking bench for the decay chopper driving a behavioural bridge
`timescale 1ns/1ps
`default_nettype none
module test_stepper_decay_chopper_control;
	import sdc_pkg::*;
	localparam int AFM = 8;
	logic        CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, er;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd;
	logic        PREADY, PSLVERR, TORQUE_SCALE_LO = 1'b0, TORQUE_SCALE_HI = 1'b0, CURRENT_INCREASING = 1'b1;
	logic        TUNING_ENABLE_PIN = 1'b0, SLEEP_IN_N = 1'b1, ENABLE_IN = 1'b1;
	logic        SUPPLY_UNDERVOLTAGE = 1'b0, LOGIC_UNDERVOLTAGE = 1'b0;
	logic [4:0]  PIN_UNDRIVEN = 5'h00, SINE_CODE = 5'h10;
	logic [1:0]  off_c = TRI_Z, dlo_c = TRI_LO, dhi_c = TRI_LO, mlo_c = TRI_HI, mhi_c = TRI_LO;
	logic [11:0] trip_dly = 12'h000, zero_dly = 12'hfff;
	logic        FAULT_OUT_N_O, FAULT_OUT_N_OE_N, BRIDGE_DRIVE, BRIDGE_FAST, BRIDGE_SLOW, SENSE_BLANKED;
	logic        CHARGE_PUMP_EN, AUX_REGULATOR_EN, INDEXER_RUN, WINDING_SENSE_INPUT, CURRENT_NEAR_ZERO;
	int          error_cnt = 0, tests_run = 0, cyc = 0, bl, dr, fs, sl, of, bad;
	// Tri-level pins split into level and float; the fault line has a pull-up
	wire OFF_TIME_SELECT_LVL = (off_c == TRI_HI);
	wire OFF_TIME_SELECT_FLT = (off_c == TRI_Z);
	wire DECAY_SELECT_LO_LVL = (dlo_c == TRI_HI);
	wire DECAY_SELECT_LO_FLT = (dlo_c == TRI_Z);
	wire DECAY_SELECT_HI_LVL = (dhi_c == TRI_HI);
	wire DECAY_SELECT_HI_FLT = (dhi_c == TRI_Z);
	wire STEP_MODE_SELECT_LO_LVL = (mlo_c == TRI_HI);
	wire STEP_MODE_SELECT_LO_FLT = (mlo_c == TRI_Z);
	wire STEP_MODE_SELECT_HI_LVL = (mhi_c == TRI_HI);
	wire STEP_MODE_SELECT_HI_FLT = (mhi_c == TRI_Z);
	wire FAULT_OUT_N_I = FAULT_OUT_N_OE_N ? 1'b1 : FAULT_OUT_N_O;
	sdc_chopper #(.AF_MAX(AFM), .LONG_MULT(2)) i_sdc_chopper (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .OFF_TIME_SELECT_LVL(OFF_TIME_SELECT_LVL), .OFF_TIME_SELECT_FLT(OFF_TIME_SELECT_FLT),
		.DECAY_SELECT_LO_LVL(DECAY_SELECT_LO_LVL), .DECAY_SELECT_LO_FLT(DECAY_SELECT_LO_FLT),
		.DECAY_SELECT_HI_LVL(DECAY_SELECT_HI_LVL), .DECAY_SELECT_HI_FLT(DECAY_SELECT_HI_FLT),
		.STEP_MODE_SELECT_LO_LVL(STEP_MODE_SELECT_LO_LVL), .STEP_MODE_SELECT_LO_FLT(STEP_MODE_SELECT_LO_FLT),
		.STEP_MODE_SELECT_HI_LVL(STEP_MODE_SELECT_HI_LVL), .STEP_MODE_SELECT_HI_FLT(STEP_MODE_SELECT_HI_FLT),
		.TORQUE_SCALE_LO(TORQUE_SCALE_LO), .TORQUE_SCALE_HI(TORQUE_SCALE_HI), .TUNING_ENABLE_PIN(TUNING_ENABLE_PIN),
		.SLEEP_IN_N(SLEEP_IN_N), .ENABLE_IN(ENABLE_IN), .PIN_UNDRIVEN(PIN_UNDRIVEN), .SINE_CODE(SINE_CODE),
		.CURRENT_INCREASING(CURRENT_INCREASING), .WINDING_SENSE_INPUT(WINDING_SENSE_INPUT),
		.CURRENT_NEAR_ZERO(CURRENT_NEAR_ZERO), .SUPPLY_UNDERVOLTAGE(SUPPLY_UNDERVOLTAGE),
		.LOGIC_UNDERVOLTAGE(LOGIC_UNDERVOLTAGE), .FAULT_OUT_N_I(FAULT_OUT_N_I), .FAULT_OUT_N_O(FAULT_OUT_N_O),
		.FAULT_OUT_N_OE_N(FAULT_OUT_N_OE_N), .BRIDGE_DRIVE(BRIDGE_DRIVE), .BRIDGE_FAST(BRIDGE_FAST),
		.BRIDGE_SLOW(BRIDGE_SLOW), .SENSE_BLANKED(SENSE_BLANKED), .CHARGE_PUMP_EN(CHARGE_PUMP_EN),
		.AUX_REGULATOR_EN(AUX_REGULATOR_EN), .INDEXER_RUN(INDEXER_RUN));
	sdc_bridge_model i_sdc_bridge_model (.clk(CLK), .bridge_drive(BRIDGE_DRIVE), .bridge_fast(BRIDGE_FAST),
		.trip_dly(trip_dly), .zero_dly(zero_dly), .sense_trip(WINDING_SENSE_INPUT), .near_zero(CURRENT_NEAR_ZERO));
	// Clock, and a cycle ceiling that cuts a hang short
	always #10 CLK = ~CLK;
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			error_cnt++;
			$display("mismatch at %0t: run too long", $time);
			print_verdict();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// One APB transfer; request held until PREADY is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1) @(posedge CLK);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	// Measure one whole PWM cycle; the cycle in progress is skipped so new settings apply
	task automatic pwm();
		int ph, n;
		{bl, dr, fs, sl, of, bad, ph, n} = '0;
		while (ph < 4 && n < 9000)
		begin
			@(posedge CLK);
			#1;
			n++;
			ph = (ph == 0 && BRIDGE_DRIVE !== 1'b1) ? 1 : (ph == 1 && BRIDGE_DRIVE === 1'b1) ? 2 : ph;
			ph = (ph == 3 && BRIDGE_DRIVE === 1'b1) ? 4 : (ph == 2 && BRIDGE_DRIVE !== 1'b1) ? 3 : ph;
			dr += (ph == 2);
			bl += (ph == 2 && SENSE_BLANKED === 1'b1);
			fs += (ph == 3 && BRIDGE_FAST === 1'b1);
			sl += (ph == 3 && BRIDGE_SLOW === 1'b1);
			of += (ph == 3);
			bad |= (ph == 3 && BRIDGE_FAST === 1'b1 && sl > 0);
		end
		cmp(32'(ph), 32'h4);
	endtask : pwm
	// Blanking level worked out from torque scale and sine code
	function automatic logic [11:0] exp_blank(input int t, input int c);
		int v;
		v = (c >= 9) ? 3 : (c >= 5) ? 2 : (c >= 3) ? 1 : 0;
		v = (t == 0) ? v : (t == 1) ? ((v == 3) ? 2 : v) : (t == 2) ? ((v > 0) ? v - 1 : 0) : ((v == 3) ? 1 : 0);
		return (v == 3) ? BLANK_1800 : (v == 2) ? BLANK_1500 : (v == 1) ? BLANK_1200 : BLANK_0900;
	endfunction : exp_blank
	task automatic t_apb();
		apb(1'b0, ADDR_CTRL, 32'h0);
		cmp(rd, {31'h0, CTRL_RST});
		apb(1'b0, ADDR_TIMING, 32'h0);
		cmp(rd, {4'h0, OFF_10, 4'h0, BLANK_1800});
		apb(1'b0, 8'h0c, 32'h0);
		cmp({er, rd[30:0]}, 32'h80000000);
		apb(1'b1, ADDR_CTRL, 32'h0);
		repeat (3) @(posedge CLK);
		#1;
		cmp(32'({BRIDGE_DRIVE, BRIDGE_FAST, BRIDGE_SLOW}), 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h1);
		pwm();
		@(posedge CLK);
		PIN_UNDRIVEN <= 5'h10;
		repeat (3) @(posedge CLK);
		#1;
		cmp(32'({BRIDGE_DRIVE, BRIDGE_FAST, BRIDGE_SLOW}), 32'h0);
		@(posedge CLK);
		PIN_UNDRIVEN <= 5'h00;
		$display("test apb done");
	endtask : t_apb
	task automatic t_blank();
		int codes [7] = '{16, 9, 8, 5, 4, 3, 1};
		for (int t = 0; t < 4; t++)
		begin
			foreach (codes[i])
			begin
				@(posedge CLK);
				{TORQUE_SCALE_HI, TORQUE_SCALE_LO} <= 2'(t);
				SINE_CODE <= 5'(codes[i]);
				pwm();
				// The comparator is first looked at in the last cycle of the blanking interval
				cmp(32'(bl), 32'(exp_blank(t, codes[i])) - 32'h1);
				cmp(32'(dr), 32'(exp_blank(t, codes[i])));
			end
		end
		@(posedge CLK);
		{TORQUE_SCALE_HI, TORQUE_SCALE_LO} <= 2'h0;
		SINE_CODE <= 5'h10;
		$display("test blank done");
	endtask : t_blank
	task automatic t_off();
		logic [1:0]  c [3] = '{TRI_LO, TRI_HI, TRI_Z};
		logic [11:0] e [3] = '{OFF_20, OFF_30, OFF_10};
		foreach (c[i])
		begin
			@(posedge CLK);
			off_c <= c[i];
			pwm();
			cmp(32'(of), 32'(e[i]));
		end
		$display("test off done");
	endtask : t_off
	// Fixed decay: fast time first, slow for the rest of the off time
	task automatic t_dec(input logic [1:0] h, input logic [1:0] l, input logic inc, input int efs);
		@(posedge CLK);
		dhi_c <= h;
		dlo_c <= l;
		CURRENT_INCREASING <= inc;
		pwm();
		cmp(32'(fs), 32'(efs));
		cmp(32'(sl), 32'(int'(OFF_10) - efs));
		cmp(32'(bad), 32'h0);
	endtask : t_dec
	task automatic t_uv();
		@(posedge CLK);
		SUPPLY_UNDERVOLTAGE <= 1'b1;
		repeat (3) @(posedge CLK);
		#1;
		cmp(32'({BRIDGE_DRIVE, BRIDGE_FAST, BRIDGE_SLOW, CHARGE_PUMP_EN, FAULT_OUT_N_I}), 32'h0);
		cmp(32'({INDEXER_RUN, AUX_REGULATOR_EN}), 32'h3);
		@(posedge CLK);
		LOGIC_UNDERVOLTAGE <= 1'b1;
		repeat (3) @(posedge CLK);
		#1;
		cmp(32'({INDEXER_RUN, AUX_REGULATOR_EN, FAULT_OUT_N_I}), 32'h0);
		@(posedge CLK);
		LOGIC_UNDERVOLTAGE <= 1'b0;
		repeat (4) @(posedge CLK);
		#1;
		cmp(32'(FAULT_OUT_N_I), 32'h0);
		@(posedge CLK);
		SUPPLY_UNDERVOLTAGE <= 1'b0;
		for (int n = 0; n < 20 && FAULT_OUT_N_OE_N !== 1'b1; n++) @(posedge CLK);
		#1;
		cmp(32'({FAULT_OUT_N_OE_N, CHARGE_PUMP_EN, INDEXER_RUN}), 32'h7);
		pwm();
		$display("test undervoltage done");
	endtask : t_uv
	// Adaptive tuning: capture at wake only, fraction walks and saturates
	task automatic t_tune();
		@(posedge CLK);
		TUNING_ENABLE_PIN <= 1'b1;
		dhi_c <= TRI_LO;
		dlo_c <= TRI_LO;
		CURRENT_INCREASING <= 1'b1;
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp(32'(rd[13]), 32'h0);
		SLEEP_IN_N <= 1'b0;
		repeat (3) @(posedge CLK);
		SLEEP_IN_N <= 1'b1;
		repeat (4) @(posedge CLK);
		TUNING_ENABLE_PIN <= 1'b0;
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp(32'(rd[13]), 32'h1);
		repeat (AFM + 4) pwm();
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp(32'(rd[9:6]), 32'(AFM));
		pwm();
		cmp(32'(sl), 32'h0);
		trip_dly <= 12'd200;
		repeat (AFM + 4) pwm();
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp(32'(rd[9:6]), 32'h0);
		pwm();
		cmp(32'(fs), 32'h0);
		CURRENT_INCREASING <= 1'b0;
		pwm();
		cmp(32'(fs > 0), 32'h1);
		$display("test tuning done");
	endtask : t_tune
	task automatic print_verdict();
		$display("counts: tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// Main sequence
	initial
	begin
		repeat (20) @(posedge CLK);
		SYS_RST <= 1'b0;
		repeat (2) @(posedge CLK);
		t_apb();
		t_blank();
		t_off();
		t_dec(TRI_LO, TRI_LO, 1'b0, 0);
		t_dec(TRI_LO, TRI_HI, 1'b0, 2 * int'(BLANK_1800));
		t_dec(TRI_HI, TRI_LO, 1'b0, int'(OFF_10) * 3 / 10);
		t_dec(TRI_HI, TRI_HI, 1'b1, int'(OFF_10) * 3 / 10);
		t_dec(TRI_HI, TRI_HI, 1'b0, int'(OFF_10) * 3 / 10);
		t_dec(TRI_LO, TRI_Z, 1'b0, int'(OFF_10) * 6 / 10);
		t_dec(TRI_HI, TRI_Z, 1'b1, 0);
		t_dec(TRI_HI, TRI_Z, 1'b0, int'(OFF_10));
		t_dec(TRI_Z, TRI_LO, 1'b1, int'(BLANK_1800));
		t_dec(TRI_Z, TRI_HI, 1'b1, int'(OFF_10) * 6 / 10);
		t_dec(TRI_Z, TRI_Z, 1'b1, int'(OFF_10));
		t_dec(TRI_Z, TRI_Z, 1'b0, int'(OFF_10));
		zero_dly <= 12'd20;
		pwm();
		cmp(32'(fs >= 19 && fs <= 22 && sl == 0 && of == int'(OFF_10)), 32'h1);
		zero_dly <= 12'hfff;
		mlo_c <= TRI_LO;
		t_dec(TRI_HI, TRI_Z, 1'b0, 0);
		mlo_c <= TRI_HI;
		$display("test decay done");
		t_uv();
		t_tune();
		print_verdict();
	end
endmodule : test_stepper_decay_chopper_control
`default_nettype wire
